/* File: core/auc_timing.sv */
// uart command front end and reply timing of the converter
// assumes rx is synchronous to clk; baud_div >= 16 clocks per bit
module auc_timing (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        turbo,
  input  wire logic        auto_read,
  input  wire logic [15:0] baud_div,
  input  wire logic        rx,
  input  wire logic        conv_done,
  input  wire logic [23:0] conv_data,
  input  wire logic [7:0]  reg_rdata,
  output logic             tx,
  output logic             result_ready_n,
  output logic [2:0]       reg_raddr
);
  localparam logic [7:0] DIV_N = 8'(auc_pkg::CORE_DIV_NORMAL);
  localparam logic [7:0] DIV_T = 8'(auc_pkg::CORE_DIV_TURBO);
  localparam logic [16:0] TO_N = 17'(auc_pkg::TIMEOUT_NORMAL);
  localparam logic [16:0] TO_T = 17'(auc_pkg::TIMEOUT_TURBO);

  // tick dividers
  logic [7:0]  core_cnt, next_core_cnt;
  logic [1:0]  mod_cnt, next_mod_cnt;
  logic        core_tick, mod_tick;
  // receiver
  auc_pkg::auc_rx_e rx_st, next_rx_st;
  logic [15:0] rx_cnt, next_rx_cnt;
  logic [2:0]  rx_bit, next_rx_bit;
  logic [7:0]  rx_shift, next_rx_shift;
  logic [16:0] idle_mods, next_idle_mods;
  logic        cmd_valid;
  logic        soft_rst, next_soft_rst;
  // reply sequencer
  auc_pkg::auc_sq_e sq_st, next_sq_st;
  logic [16:0] sq_cnt, next_sq_cnt;
  logic [1:0]  sq_len, next_sq_len;
  logic [1:0]  sq_idx, next_sq_idx;
  logic        sq_reg, next_sq_reg;
  logic [23:0] result, next_result;
  logic [2:0]  next_reg_raddr;
  // serializer
  logic        tx_busy, next_tx_busy;
  logic [8:0]  tx_shift, next_tx_shift;
  logic [3:0]  tx_bits, next_tx_bits;
  logic [15:0] tx_cnt, next_tx_cnt;
  logic        next_tx;
  // ready line
  logic        next_ready_n;
  logic [1:0]  high_mods, next_high_mods;
  logic [2:0]  low_cores, next_low_cores;
  logic [2:0]  rise_cnt, next_rise_cnt;
  logic        fall_pend, next_fall_pend;
  logic        rise_pend, next_rise_pend;
  // buffer handshake
  auc_pkg::auc_byte_s push_byte, pop_byte;
  logic        push_valid, push_ready, pop_valid, pop_ready;
  logic        start_reply, reply_is_reg;
  logic        sw_rst;

  assign sw_rst = rst_n && !soft_rst;
  assign core_tick = (core_cnt == 8'h00);
  assign mod_tick  = core_tick && (mod_cnt == 2'h0);

  auc_buf2 #(.WIDTH($bits(auc_pkg::auc_byte_s))) u_buf (
    .clk       (clk),
    .rst_n     (sw_rst),
    .in_valid  (push_valid),
    .in_ready  (push_ready),
    .in_data   (push_byte),
    .out_valid (pop_valid),
    .out_ready (pop_ready),
    .out_data  (pop_byte)
  );

  always_comb begin
    next_core_cnt = core_tick ? ((turbo ? DIV_T : DIV_N) - 8'h01) : core_cnt - 8'h01;
    next_mod_cnt  = core_tick ? mod_cnt - 2'h1 : mod_cnt;
    next_rx_st     = rx_st;
    next_rx_cnt    = rx_cnt;
    next_rx_bit    = rx_bit;
    next_rx_shift  = rx_shift;
    next_idle_mods = 17'h0;
    next_soft_rst  = 1'b0;
    cmd_valid      = 1'b0;
    if (rx_cnt != 16'h0) begin
      next_rx_cnt = rx_cnt - 16'h1;
    end
    case (rx_st)
      auc_pkg::RX_IDLE: begin
        if (!rx) begin
          next_rx_st  = auc_pkg::RX_START;
          next_rx_cnt = {1'b0, baud_div[15:1]};
        end
      end
      auc_pkg::RX_START: begin
        if (rx_cnt == 16'h0) begin
          next_rx_st  = rx ? auc_pkg::RX_IDLE : auc_pkg::RX_DATA;
          // reload one short so samples stay exactly one bit apart
          next_rx_cnt = baud_div - 16'h1;
          next_rx_bit = 3'h0;
        end
      end
      auc_pkg::RX_DATA: begin
        if (rx_cnt == 16'h0) begin
          next_rx_shift = {rx, rx_shift[7:1]};
          next_rx_cnt   = baud_div - 16'h1;
          next_rx_bit   = rx_bit + 3'h1;
          if (rx_bit == 3'h7) begin
            next_rx_st = auc_pkg::RX_STOP;
          end
        end
      end
      default: begin
        // decode happens at mid stop bit, so the reference point moves with baud rate
        if (rx_cnt == 16'h0) begin
          next_rx_st = auc_pkg::RX_IDLE;
          cmd_valid  = rx;
        end
      end
    endcase
    if (rx_st != auc_pkg::RX_IDLE) begin
      next_idle_mods = idle_mods + {16'h0, mod_tick};
      if (idle_mods >= (turbo ? TO_T : TO_N)) begin
        next_rx_st = auc_pkg::RX_IDLE;
      end
    end
    if (cmd_valid && rx_shift == auc_pkg::CMD_RESET) begin
      next_soft_rst = 1'b1;
    end
  end

  always_comb begin
    next_ready_n   = result_ready_n;
    next_high_mods = (result_ready_n && mod_tick && high_mods != 2'h3) ? high_mods + 2'h1 : high_mods;
    next_low_cores = (!result_ready_n && core_tick && low_cores != 3'h7) ? low_cores + 3'h1 : low_cores;
    next_rise_cnt  = rise_cnt;
    next_fall_pend = fall_pend;
    next_rise_pend = rise_pend;
    next_result    = result;
    next_reg_raddr = reg_raddr;
    start_reply    = 1'b0;
    reply_is_reg   = 1'b0;
    if (rise_cnt != 3'h0 && core_tick) begin
      next_rise_cnt = rise_cnt - 3'h1;
      if (rise_cnt == 3'h1) begin
        next_ready_n   = 1'b1;
        next_high_mods = 2'h0;
      end
    end
    // one tick beyond the minimum: the first tick may land just after the edge
    if (result_ready_n && fall_pend && high_mods > 2'(auc_pkg::HIGH_MOD_TICKS)) begin
      next_ready_n   = 1'b0;
      next_fall_pend = 1'b0;
      next_low_cores = 3'h0;
    end
    if (!result_ready_n && rise_pend && low_cores > 3'(auc_pkg::LOW_CORE_TICKS)) begin
      next_ready_n   = 1'b1;
      next_high_mods = 2'h0;
      next_rise_pend = 1'b0;
      next_fall_pend = 1'b1;
      start_reply    = 1'b1;
    end
    if (cmd_valid && !auto_read && rx_shift == auc_pkg::CMD_READ_DATA) begin
      start_reply = 1'b1;
      if (!result_ready_n) begin
        next_rise_cnt = 3'(auc_pkg::RISE_CORE_TICKS);
      end
    end
    if (cmd_valid && (rx_shift & auc_pkg::CMD_READ_REG_MSK) == auc_pkg::CMD_READ_REG) begin
      start_reply    = 1'b1;
      reply_is_reg   = 1'b1;
      next_reg_raddr = rx_shift[auc_pkg::REG_ADDR_LSB +: 3];
    end
    // a conversion landing on the clearing cycle still sets its pending flag
    if (conv_done) begin
      next_result = conv_data;
      if (auto_read) begin
        next_rise_pend = 1'b1;
        next_fall_pend = next_fall_pend || result_ready_n;
      end else begin
        next_fall_pend = 1'b1;
      end
    end
  end

  always_comb begin
    next_sq_st    = sq_st;
    next_sq_cnt   = (sq_cnt != 17'h0) ? sq_cnt - 17'h1 : sq_cnt;
    next_sq_len   = sq_len;
    next_sq_idx   = sq_idx;
    next_sq_reg   = sq_reg;
    push_valid    = (sq_st != auc_pkg::SQ_IDLE) && (sq_idx != sq_len);
    push_byte     = sq_reg ? reg_rdata : result[sq_idx * 8 +: 8];
    pop_ready     = (sq_st == auc_pkg::SQ_SEND) && !tx_busy;
    next_tx_busy  = tx_busy;
    next_tx_shift = tx_shift;
    next_tx_bits  = tx_bits;
    next_tx_cnt   = (tx_cnt != 16'h0) ? tx_cnt - 16'h1 : tx_cnt;
    next_tx       = tx;
    if (push_valid && push_ready) begin
      next_sq_idx = sq_idx + 2'h1; // stalls here while the buffer is full
    end
    case (sq_st)
      auc_pkg::SQ_IDLE: begin
        if (start_reply) begin
          next_sq_st  = auc_pkg::SQ_WAIT;
          next_sq_cnt = 17'(baud_div) * 17'(auc_pkg::REPLY_BAUDS) - 17'h2;
          next_sq_idx = 2'h0;
          next_sq_len = reply_is_reg ? 2'h1 : 2'(auc_pkg::RESULT_BYTES);
          next_sq_reg = reply_is_reg;
        end
      end
      auc_pkg::SQ_WAIT: begin
        if (sq_cnt == 17'h0) begin
          next_sq_st = auc_pkg::SQ_SEND;
        end
      end
      default: begin
        if (sq_idx == sq_len && !pop_valid && !tx_busy) begin
          next_sq_st = auc_pkg::SQ_IDLE;
        end
      end
    endcase
    if (pop_ready && pop_valid) begin
      next_tx_busy  = 1'b1;
      next_tx       = 1'b0;
      next_tx_shift = {1'b1, pop_byte.data};
      next_tx_bits  = 4'h9;
      next_tx_cnt   = baud_div - 16'h1;
    end else if (tx_busy && tx_cnt == 16'h0) begin
      if (tx_bits == 4'h0) begin
        next_tx_busy = 1'b0;
      end else begin
        next_tx       = tx_shift[0];
        next_tx_shift = {1'b1, tx_shift[8:1]};
        next_tx_bits  = tx_bits - 4'h1;
        next_tx_cnt   = baud_div - 16'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      core_cnt  <= 8'h00;
      mod_cnt   <= 2'h0;
      soft_rst  <= 1'b0;
    end else begin
      core_cnt  <= next_core_cnt;
      mod_cnt   <= next_mod_cnt;
      soft_rst  <= next_soft_rst;
    end
    if (!sw_rst) begin
      rx_st          <= auc_pkg::RX_IDLE;
      rx_cnt         <= 16'h0;
      rx_bit         <= 3'h0;
      rx_shift       <= 8'h00;
      idle_mods      <= 17'h0;
      sq_st          <= auc_pkg::SQ_IDLE;
      sq_cnt         <= 17'h0;
      sq_len         <= 2'h0;
      sq_idx         <= 2'h0;
      sq_reg         <= 1'b0;
      result         <= 24'h0;
      reg_raddr      <= 3'h0;
      tx_busy        <= 1'b0;
      tx_shift       <= 9'h1ff;
      tx_bits        <= 4'h0;
      tx_cnt         <= 16'h0;
      tx             <= 1'b1;
      result_ready_n <= 1'b1;
      high_mods      <= 2'h0;
      low_cores      <= 3'h0;
      rise_cnt       <= 3'h0;
      fall_pend      <= 1'b0;
      rise_pend      <= 1'b0;
    end else begin
      rx_st          <= next_rx_st;
      rx_cnt         <= next_rx_cnt;
      rx_bit         <= next_rx_bit;
      rx_shift       <= next_rx_shift;
      idle_mods      <= next_idle_mods;
      sq_st          <= next_sq_st;
      sq_cnt         <= next_sq_cnt;
      sq_len         <= next_sq_len;
      sq_idx         <= next_sq_idx;
      sq_reg         <= next_sq_reg;
      result         <= next_result;
      reg_raddr      <= next_reg_raddr;
      tx_busy        <= next_tx_busy;
      tx_shift       <= next_tx_shift;
      tx_bits        <= next_tx_bits;
      tx_cnt         <= next_tx_cnt;
      tx             <= next_tx;
      result_ready_n <= next_ready_n;
      high_mods      <= next_high_mods;
      low_cores      <= next_low_cores;
      rise_cnt       <= next_rise_cnt;
      fall_pend      <= next_fall_pend;
      rise_pend      <= next_rise_pend;
    end
  end
endmodule

/* File: core/auc_pkg.sv */
// constants and carrier types for the adc uart response timing block
// assumes a single 200 MHz clock and a host that speaks 8-N-1 on rx/tx
// Functional notes
// - abandon partial command after mode-dependent timeout
// - core tick 1.024 MHz normal, 2.048 turbo
// - modulator tick is a quarter of core
// - manual mode: ready rises 7 core ticks after read
// - manual mode: reply start bit 2 baud after read
// - auto mode: reply start bit 2 baud after rise
// - ready stays high at least 2 modulator ticks
// - auto mode: ready stays low at least 4 core ticks
// - register reply start bit 2 baud after decode
// - decode instant is at mid stop bit, so baud rate
package auc_pkg;
  localparam int unsigned F_CLK_HZ         = 200_000_000;
  localparam int unsigned F_CORE_NORMAL_HZ = 1_024_000;
  localparam int unsigned F_CORE_TURBO_HZ  = 2_048_000;
  // integer dividers: the core tick runs about 0.2 percent fast in normal mode and 0.7 percent fast in turbo, inside the oscillator tolerance
  localparam int unsigned CORE_DIV_NORMAL  = F_CLK_HZ / F_CORE_NORMAL_HZ;
  localparam int unsigned CORE_DIV_TURBO   = F_CLK_HZ / F_CORE_TURBO_HZ;
  localparam int unsigned MOD_DIV          = 4;
  localparam int unsigned TIMEOUT_NORMAL   = 32760;
  localparam int unsigned TIMEOUT_TURBO    = 65520;
  localparam int unsigned RISE_CORE_TICKS  = 7;
  localparam int unsigned HIGH_MOD_TICKS   = 2;
  localparam int unsigned LOW_CORE_TICKS   = 4;
  localparam int unsigned REPLY_BAUDS      = 2;
  localparam int unsigned RESULT_BYTES     = 3;
  localparam logic [15:0] BAUD_DIV_MIN     = 16'h0010;
  localparam logic [7:0]  CMD_RESET        = 8'h06;
  localparam logic [7:0]  CMD_READ_DATA    = 8'h10;
  localparam logic [7:0]  CMD_READ_REG     = 8'h20;
  localparam logic [7:0]  CMD_READ_REG_MSK = 8'hf0;
  localparam int unsigned REG_ADDR_LSB     = 1;

  typedef struct packed {
    logic [7:0] data;
  } auc_byte_s;

  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b10,
    RX_STOP  = 2'b11
  } auc_rx_e;

  typedef enum logic [1:0] {
    SQ_IDLE = 2'b00,
    SQ_WAIT = 2'b01,
    SQ_SEND = 2'b10
  } auc_sq_e;
endpackage

/* File: core/auc_buf2.sv */
// two-entry buffer with valid/ready on both sides
// assumes one clock and synchronous active-low reset
module auc_buf2 #(
  parameter int unsigned WIDTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  logic [WIDTH-1:0] mem [2];
  logic             wr_ptr;
  logic             rd_ptr;
  logic [1:0]       count;
  logic             next_wr_ptr;
  logic             next_rd_ptr;
  logic [1:0]       next_count;
  logic             push;
  logic             pop;

  assign in_ready  = (count != 2'h2);
  assign out_valid = (count != 2'h0);
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    next_wr_ptr = wr_ptr ^ push;
    next_rd_ptr = rd_ptr ^ pop;
    next_count  = count + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count  <= 2'h0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule

/* File: verif/auc_host.sv */
// host side model: drives rx and collects the reply bytes seen on tx
// assumes tx and rx are 8-N-1, idle high, with baud_div clocks per bit
module auc_host (
  input  wire logic        clk,
  input  wire logic [15:0] baud_div,
  input  wire logic        tx,
  output logic             rx
);
  timeunit 1ns;
  timeprecision 1ps;
  int unsigned cyc = 0;
  int unsigned t_dec = 0;
  int unsigned t_start[$];
  logic [7:0]  got[$];
  logic [7:0]  sh;

  initial rx = 1'b1;
  always @(posedge clk) cyc <= cyc + 1;

  // start low, eight bits lsb first, stop high; t_dec marks the mid stop bit
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rx <= f[i];
      repeat (baud_div) @(posedge clk);
    end
    t_dec = cyc - baud_div / 2;
  endtask

  // a bad stop bit is kept as unknown so the bench cannot mistake it for data
  always begin
    @(negedge tx);
    t_start.push_back(cyc);
    repeat (baud_div / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (baud_div) @(posedge clk);
      sh[i] = tx;
    end
    repeat (baud_div) @(posedge clk);
    got.push_back(tx === 1'b1 ? sh : 8'hxx);
  end
endmodule

/* File: verif/auc_timing_asserts.sv */
// port-level timing checks for the reply timing block
// assumes one clock and the synchronous active-low reset of the block
module auc_chk (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        turbo,
  input wire logic        auto_read,
  input wire logic [15:0] baud_div,
  input wire logic        conv_done,
  input wire logic        tx,
  input wire logic        result_ready_n,
  input wire logic [2:0]  reg_raddr
);
  timeunit 1ns;
  timeprecision 1ps;
  int unsigned div;
  int unsigned hi_cnt;
  int unsigned lo_cnt;
  int unsigned low_run;
  int unsigned rise_cnt;

  assign div = turbo ? auc_pkg::CORE_DIV_TURBO : auc_pkg::CORE_DIV_NORMAL;

  // the fall check allows one extra tick, since the tick phase is free running
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hi_cnt   <= 0;
      lo_cnt   <= 0;
      low_run  <= 0;
      rise_cnt <= 32'h00ff_ffff;
    end else begin
      hi_cnt   <= result_ready_n ? hi_cnt + 1 : 0;
      lo_cnt   <= result_ready_n ? 0 : lo_cnt + 1;
      low_run  <= tx ? 0 : low_run + 1;
      rise_cnt <= $rose(result_ready_n) ? 1 : (rise_cnt < 32'h00ff_ffff ? rise_cnt + 1 : rise_cnt);
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_quiet;
    tx && result_ready_n && reg_raddr == 3'h0;
  endsequence

  chk_reset_quiet: assert property ($rose(rst_n) |-> s_quiet [*4])
    else $error("outputs not idle after reset");
  chk_high_hold: assert property ($fell(result_ready_n) |->
    hi_cnt >= auc_pkg::HIGH_MOD_TICKS * auc_pkg::MOD_DIV * div) else $error("ready high too short");
  chk_low_hold: assert property (auto_read && $rose(result_ready_n) |->
    lo_cnt >= auc_pkg::LOW_CORE_TICKS * div) else $error("ready low too short");
  chk_ready_falls: assert property (conv_done && result_ready_n &&
    hi_cnt >= (auc_pkg::HIGH_MOD_TICKS + 1) * auc_pkg::MOD_DIV * div |-> ##[1:2] !result_ready_n)
    else $error("ready did not fall on new result");
  chk_bit_width: assert property ($rose(tx) |-> low_run % baud_div == 0)
    else $error("tx low run not whole bits");
  chk_frame_low: assert property ($rose(tx) |-> low_run <= 9 * baud_div)
    else $error("tx low longer than a frame");
  chk_auto_early: assert property (auto_read && $fell(tx) && rise_cnt < 3 * baud_div |->
    rise_cnt + 4 >= 2 * baud_div) else $error("auto reply too early");
  chk_auto_start: assert property (auto_read && rise_cnt == 2 * baud_div + 3 |-> !tx)
    else $error("auto reply start bit missing");
endmodule

bind auc_timing auc_chk i_chk (.clk(clk), .rst_n(rst_n), .turbo(turbo), .auto_read(auto_read),
  .baud_div(baud_div), .conv_done(conv_done), .tx(tx), .result_ready_n(result_ready_n), .reg_raddr(reg_raddr));

/* File: verif/auc_timing_tb.sv */
// self-checking bench for the reply timing block with a host model on rx/tx
// assumes the design, its package and the checker are compiled before it
module auc_timing_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    logic        trb;
    logic [7:0]  cmd;
    int          nb;
    logic [23:0] val;
  } auc_row_s;
  localparam int LIMIT = 98000;
  logic        clk       = 1'b0;
  logic        rst_n     = 1'b0;
  logic        turbo     = 1'b1;
  logic        auto_read = 1'b0;
  logic        conv_done = 1'b0;
  logic [15:0] baud_div;
  logic [23:0] conv_data;
  logic [7:0]  reg_rdata;
  logic [2:0]  reg_raddr;
  logic        rx;
  logic        tx;
  logic        result_ready_n;
  int          err_total = 0;
  int          compares  = 0;
  int          tick      = 0;
  int unsigned rise_cyc  = 0;
  int unsigned fall_cyc  = 0;
  auc_row_s    rows[5]   = '{'{1'b1, 8'h20, 1, 24'h00000b}, '{1'b1, 8'h26, 1, 24'h00006b},
    '{1'b0, 8'h2e, 1, 24'h0000eb}, '{1'b1, 8'h10, 3, 24'ha5c312}, '{1'b0, 8'h10, 3, 24'h0f1e2d}};

  auc_timing i_dut (.clk(clk), .rst_n(rst_n), .turbo(turbo), .auto_read(auto_read), .baud_div(baud_div),
    .rx(rx), .conv_done(conv_done), .conv_data(conv_data), .reg_rdata(reg_rdata), .tx(tx),
    .result_ready_n(result_ready_n), .reg_raddr(reg_raddr));
  auc_host i_host (.clk(clk), .baud_div(baud_div), .tx(tx), .rx(rx));

  always #2.5 clk = ~clk;
  // register file stand-in follows the address at once, so the push never sees a stale value
  assign reg_rdata = {reg_raddr, 5'h0b};
  always @(posedge result_ready_n) rise_cyc = i_host.cyc;
  always @(negedge result_ready_n) fall_cyc = i_host.cyc;
  always @(posedge clk) begin
    tick <= tick + 1;
    if (tick == LIMIT) begin
      err_total++;
      report_and_stop();
    end
  end

  task automatic report_and_stop;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic near(input string what, input int exp, input int got, input int tol);
    compares++;
    if (got < exp - tol || got > exp + tol) begin
      err_total++;
      $display("MISMATCH %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  task automatic get_reply(input int nb, output logic [23:0] v);
    v = 24'h000000;
    for (int i = 0; i < 30000 && i_host.got.size() < nb; i++) @(posedge clk);
    for (int i = 0; i < nb; i++) v[8*i +: 8] = (i < i_host.got.size()) ? i_host.got[i] : 8'hxx;
  endtask

  task automatic fresh;
    i_host.got.delete();
    i_host.t_start.delete();
  endtask

  task automatic pulse_conv(input logic [23:0] d);
    conv_data <= d;
    conv_done <= 1'b1;
    @(posedge clk);
    conv_done <= 1'b0;
  endtask

  initial begin
    logic [23:0] v;
    int          dv;
    baud_div  <= 16'h0020;
    conv_data <= 24'h000000;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (16000) @(posedge clk);
    for (int i = 0; i < 5; i++) begin
      turbo <= rows[i].trb;
      dv = rows[i].trb ? auc_pkg::CORE_DIV_TURBO : auc_pkg::CORE_DIV_NORMAL;
      repeat (2000) @(posedge clk);
      fresh();
      if (rows[i].nb == 3) begin
        pulse_conv(rows[i].val);
        repeat (2) @(posedge clk);
        chk("ready low", 32'h0, {31'h0, result_ready_n});
      end
      i_host.send(rows[i].cmd);
      get_reply(rows[i].nb, v);
      repeat (1500) @(posedge clk);
      chk("reply", {8'h0, rows[i].val}, {8'h0, v});
      near("reply delay", 2 * baud_div, i_host.t_start[0] - i_host.t_dec, 4);
      if (rows[i].nb == 3) near("ready rise", 7 * dv, rise_cyc - i_host.t_dec, dv + 4);
      else chk("raddr", {29'h0, rows[i].cmd[3:1]}, {29'h0, reg_raddr});
      $display("row %0d done", i);
    end
    auto_read <= 1'b1;
    turbo     <= 1'b1;
    repeat (2000) @(posedge clk);
    fresh();
    pulse_conv(24'h3c5a96);
    get_reply(3, v);
    chk("auto reply", 32'h003c5a96, {8'h0, v});
    near("auto delay", 2 * baud_div, i_host.t_start[0] - rise_cyc, 4);
    chk("low hold", 32'h1, {31'h0, (rise_cyc - fall_cyc) >= auc_pkg::LOW_CORE_TICKS * auc_pkg::CORE_DIV_TURBO});
    repeat (2000) @(posedge clk);
    fresh();
    i_host.send(8'h10);
    repeat (600) @(posedge clk);
    chk("auto read ignored", 32'h0, i_host.got.size());
    auto_read <= 1'b0;
    $display("auto mode done");
    // second command lands while the first reply is on the line
    fresh();
    i_host.send(8'h24);
    i_host.send(8'h22);
    repeat (1500) @(posedge clk);
    chk("single reply", 32'h1, i_host.got.size());
    chk("busy reply", 32'h4b, {24'h0, i_host.got[0]});
    // a slower rate moves the decode point later, and the reply must follow it
    baud_div <= 16'h0040;
    repeat (4) @(posedge clk);
    fresh();
    i_host.send(8'h2a);
    get_reply(1, v);
    chk("slow reply", 32'hab, {24'h0, v[7:0]});
    near("slow reply delay", 2 * baud_div, i_host.t_start[0] - i_host.t_dec, 4);
    chk("raddr before reset", 32'h5, {29'h0, reg_raddr});
    i_host.send(8'h06);
    repeat (3) @(posedge clk);
    chk("reset cmd", 32'h3, {27'h0, reg_raddr, tx, result_ready_n});
    baud_div <= 16'h0020;
    repeat (16000) @(posedge clk);
    fresh();
    i_host.send(8'h2e);
    repeat (164) @(posedge clk);
    rst_n <= 1'b0;
    repeat (50) @(posedge clk);
    chk("pin reset", 32'h3, {27'h0, reg_raddr, tx, result_ready_n});
    rst_n <= 1'b1;
    repeat (16000) @(posedge clk);
    $display("reset cases done");
    report_and_stop();
  end
endmodule
